// *** losp_map.svh ***
// register offsets, field positions, reset values and fixed patterns of the output formatter
`ifndef LOSP_MAP_SVH
`define LOSP_MAP_SVH
// ==================================================
// register byte addresses
`define LOSP_IFCTRL_ADDR   8'h00
`define LOSP_PATSEL_ADDR   8'h04
`define LOSP_UPCTRL_ADDR   8'h08
`define LOSP_STATUS_ADDR   8'h0C
`define LOSP_UPAT_BASE     8'h20
// ==================================================
// interface_control_reg fields
`define LOSP_SCR_BIT       0
`define LOSP_TS_BIT        1
`define LOSP_LSBSEL_BIT    2
`define LOSP_SYNCSRC_BIT   3
`define LOSP_SWSYNC_BIT    4
`define LOSP_PDMODE_BIT    5
`define LOSP_WID_LO        8
`define LOSP_WID_HI        9
// pattern_choice_reg fields
`define LOSP_ACT_BIT       0
`define LOSP_SYN_LO        4
`define LOSP_SYN_HI        5
// user_pattern_control_reg fields
`define LOSP_INV_LO        0
`define LOSP_INV_HI        3
`define LOSP_LANE_BIT      4
// ==================================================
// reset values
`define LOSP_IFCTRL_RST    32'h0000_0000
`define LOSP_PATSEL_RST    32'h0000_0000
`define LOSP_UPCTRL_RST    32'h0000_0000
`define LOSP_MIDCODE       12'h000
// fixed lane sequence, eighth word chosen as 0x000
`define LOSP_LANE_SEQ      8'h72
`endif

// *** losp_pkg.sv ***
// types of the output formatter
package losp_pkg;
  typedef enum logic [1:0] {
    LOSP_W12 = 2'b00,
    LOSP_W11 = 2'b01,
    LOSP_W10 = 2'b10,
    LOSP_W8  = 2'b11
  } losp_width_t;
  typedef enum logic [1:0] {
    LOSP_SYN_UPAT  = 2'b00,
    LOSP_SYN_LSB   = 2'b01,
    LOSP_SYN_ALL   = 2'b10,
    LOSP_SYN_RSVD  = 2'b11
  } losp_sync_t;
endpackage

// *** losp_rx_model.sv ***
// receiver model: descrambles 10-bit and 8-bit bus A words, passes other widths, and tracks link readiness
`timescale 1ns/10ps
`default_nettype none
module losp_rx_model (
  input  wire logic        clk_i,
  input  wire logic [11:0] y_i,
  input  wire logic [1:0]  width_i,
  input  wire logic        oe_i,
  output logic      [11:0] d_o,
  output logic             valid_o
);
  logic [2:0] hold_r = 3'd7;
  always_comb begin
    d_o = y_i;
    case (width_i)
      2'd2: d_o = y_i ^ {{8{y_i[2]}}, 1'b0, y_i[3], 1'b0, y_i[2]};
      2'd3: d_o = y_i ^ {{6{y_i[4]}}, 1'b0, y_i[5], 3'b000, y_i[4]};
      default: d_o = y_i;
    endcase
  end
  // discard words while the pipeline flushes
  always_ff @(posedge clk_i) begin
    if (!oe_i) hold_r <= 3'd7;
    else if (hold_r != 3'd0) hold_r <= hold_r - 3'd1;
  end
  assign valid_o = oe_i && (hold_r == 3'd0);
endmodule // losp_rx_model
`default_nettype wire

// *** losp_top.sv ***
// output formatter: pattern selection, frame handling, scrambler and register slave
//
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "losp_map.svh"

// What this block does
// - 12-bit scramble: bits 11..2 XOR d1^d0, bit0 gets d0^d1, strobe too.
// - 11-bit scramble: bits 11..3 XOR d2^d1, bit1 gets d2^d1, strobe d1^d0.
// - scrambling only while scramble_enable is one.
// - 10-bit scramble: bits 11..4 XOR d3^d2, bit2 d2^d3, bit1 zero.
// - 10-bit: bit0 scrambled only with lsb select zero and timestamp on; strobe always.
// - 8-bit scramble: bits 11..6, bit0, strobe XOR d5^d4; bits 3..1 zero.
// - active and sync patterns chosen by pin or software, per source select.
// - pattern switches only on strobe falling edge.
// - active choice: converter samples or user pattern.
// - sync choice: user pattern, strobe on LSB, or strobe on all lanes.
// - user pattern of eight words restarts every frame.
// - short frames truncate the pattern, long frames repeat it.
// - per-bus invert: bus A bit 8 up to bus D bit 11.
// - lane sequence enable overrides user pattern with fixed sequence.
// - fixed sequence follows the same frame truncation and repetition.
// - power-down pin or mode disables data drivers.
// - foreground calibration outputs mid-code on the data path.
// - background calibration keeps samples flowing.
module losp_top #(
  parameter int NBUS = 4,
  parameter int DW   = 12
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic [NBUS*DW-1:0]   sample_i,
  input  wire logic [NBUS-1:0]      strobe_i,
  input  wire logic                 pattern_toggle_pin_i,
  input  wire logic                 power_down_pin_i,
  input  wire logic                 fg_cal_busy_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic                 wb_we_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  output logic      [NBUS*DW-1:0]   data_o,
  output logic      [NBUS-1:0]      strobe_o,
  output logic                      data_oe_o
);
  import losp_pkg::*;

  // fixed lane sequence, one bit per word index
  localparam logic [7:0] LANE_SEQ = `LOSP_LANE_SEQ;

  // ==================================================
  // state
  typedef struct packed {
    logic [1:0]          pin_sync;
    logic [1:0]          pd_sync;
    logic [31:0]         ifctrl;
    logic [31:0]         patsel;
    logic [31:0]         upctrl;
    logic [7:0][DW-1:0]  upat;
    logic                strb_prev;
    logic [2:0]          idx;
    logic                in_sync;
    logic [31:0]         rdat;
    logic                ack;
    logic [NBUS*DW-1:0]  dout;
    logic [NBUS-1:0]     sout;
    logic                oe;
  } losp_state_t;

  losp_state_t st_r;
  losp_state_t st_nxt;

  // ==================================================
  // scrambler
  function automatic logic [DW:0] scramble(input logic [DW-1:0] d, input logic s,
                                          input losp_width_t w, input logic b0en);
    logic [DW-1:0] y;
    logic          k;
    logic          sy;
    y  = d;
    k  = 1'b0;
    sy = s;
    case (w)
      LOSP_W12: begin
        k    = d[1] ^ d[0];
        y    = d ^ {{(DW-2){k}}, 2'b00};
        y[0] = d[0] ^ d[1];
        sy   = s ^ k;
      end
      LOSP_W11: begin
        k    = d[2] ^ d[1];
        y    = d ^ {{(DW-3){k}}, 3'b000};
        y[1] = k;
        if (b0en) begin
          y[0] = d[2] ^ d[1] ^ d[0];
        end
        sy   = s ^ d[1] ^ d[0];
      end
      LOSP_W10: begin
        k    = d[3] ^ d[2];
        y    = d ^ {{(DW-4){k}}, 4'h0};
        y[2] = k;
        y[1] = 1'b0;
        if (b0en) begin
          y[0] = d[0] ^ k;
        end
        sy   = s ^ k;
      end
      LOSP_W8: begin
        k      = d[5] ^ d[4];
        y      = d ^ {{(DW-6){k}}, 6'h00};
        y[4]   = k;
        y[3:1] = 3'b000;
        y[0]   = d[0] ^ k;
        sy     = s ^ k;
      end
      default: begin
        y  = d;
        sy = s;
      end
    endcase
    return {sy, y};
  endfunction

  // ==================================================
  // next state
  always_comb begin
    logic          hit;
    logic [7:0]    a;
    logic          fall;
    logic          want_sync;
    logic [DW-1:0] pw;
    logic [DW-1:0] d;
    logic          s;
    logic [DW:0]   sc;
    losp_width_t   w;
    losp_sync_t    sp;
    logic          wr_go;
    fall      = 1'b0;
    want_sync = 1'b0;
    pw        = '0;
    d         = '0;
    s         = 1'b0;
    sc        = '0;
    w         = LOSP_W12;
    sp        = LOSP_SYN_UPAT;
    st_nxt = st_r;
    a      = wb_adr_i;
    hit    = wb_cyc_i && wb_stb_i && !st_r.ack;
    // write lands at the edge where the master sees ack high
    wr_go  = wb_cyc_i && wb_stb_i && wb_we_i && st_r.ack;
    st_nxt.pin_sync = {st_r.pin_sync[0], pattern_toggle_pin_i};
    st_nxt.pd_sync  = {st_r.pd_sync[0], power_down_pin_i};
    st_nxt.ack      = hit;
    st_nxt.rdat     = 32'h0000_0000;
    if (wr_go && wb_sel_i[0]) begin
      if (a == `LOSP_IFCTRL_ADDR) begin
        st_nxt.ifctrl[7:0] = wb_dat_i[7:0];
      end
      if (a == `LOSP_PATSEL_ADDR) begin
        st_nxt.patsel[7:0] = wb_dat_i[7:0];
      end
      if (a == `LOSP_UPCTRL_ADDR) begin
        st_nxt.upctrl[7:0] = wb_dat_i[7:0];
      end
      if (a[7:5] == 3'h1 && a[1:0] == 2'b00) begin
        st_nxt.upat[a[4:2]][7:0] = wb_dat_i[7:0];
      end
    end
    if (wr_go && wb_sel_i[1]) begin
      if (a == `LOSP_IFCTRL_ADDR) begin
        st_nxt.ifctrl[9:8] = wb_dat_i[9:8];
      end
      if (a[7:5] == 3'h1 && a[1:0] == 2'b00) begin
        st_nxt.upat[a[4:2]][DW-1:8] = wb_dat_i[DW-1:8];
      end
    end
    if (hit && !wb_we_i) begin
      case (a)
        `LOSP_IFCTRL_ADDR: st_nxt.rdat = {22'h0, st_r.ifctrl[9:0]};
        `LOSP_PATSEL_ADDR: st_nxt.rdat = {24'h0, st_r.patsel[7:0]};
        `LOSP_UPCTRL_ADDR: st_nxt.rdat = {24'h0, st_r.upctrl[7:0]};
        `LOSP_STATUS_ADDR: st_nxt.rdat = {27'h0, st_r.oe, st_r.in_sync, st_r.idx};
        default: begin
          if (a[7:5] == 3'h1 && a[1:0] == 2'b00) begin
            st_nxt.rdat = {{(32-DW){1'b0}}, st_r.upat[a[4:2]]};
          end
        end
      endcase
    end
    // frame boundary on strobe falling edge of bus A
    st_nxt.strb_prev = strobe_i[0];
    fall = st_r.strb_prev && !strobe_i[0];
    want_sync = st_r.ifctrl[`LOSP_SYNCSRC_BIT] ? st_r.ifctrl[`LOSP_SWSYNC_BIT]
                                               : st_r.pin_sync[1];
    // restart each frame, wrap at eight
    if (fall) begin
      st_nxt.in_sync = want_sync;
      st_nxt.idx     = 3'd1;
    end else begin
      st_nxt.idx = st_r.idx + 3'd1;
    end
    if (st_r.upctrl[`LOSP_LANE_BIT]) begin
      pw = {DW{LANE_SEQ[fall ? 3'd0 : st_r.idx]}};
    end else begin
      pw = st_r.upat[fall ? 3'd0 : st_r.idx];
    end
    w  = losp_width_t'(st_r.ifctrl[`LOSP_WID_HI:`LOSP_WID_LO]);
    sp = losp_sync_t'(st_r.patsel[`LOSP_SYN_HI:`LOSP_SYN_LO]);
    for (int b = 0; b < NBUS; b++) begin
      d = sample_i[b*DW +: DW];
      s = strobe_i[b];
      if (st_nxt.in_sync) begin
        case (sp)
          LOSP_SYN_UPAT: d = pw;
          LOSP_SYN_LSB:  d[0] = s;
          LOSP_SYN_ALL:  d = {DW{s}};
          default:       d = pw;
        endcase
      end else if (st_r.patsel[`LOSP_ACT_BIT]) begin
        d = pw;
      end
      if ((!st_nxt.in_sync || sp == LOSP_SYN_UPAT || sp == LOSP_SYN_RSVD) &&
          (st_nxt.in_sync || st_r.patsel[`LOSP_ACT_BIT]) && st_r.upctrl[b]) begin
        d[8+b] = ~d[8+b];
      end
      // mid-code during foreground calibration, otherwise samples pass
      if (fg_cal_busy_i && !st_nxt.in_sync && !st_r.patsel[`LOSP_ACT_BIT]) begin
        d = `LOSP_MIDCODE;
      end
      sc = scramble(d, s, w, !st_r.ifctrl[`LOSP_LSBSEL_BIT] && st_r.ifctrl[`LOSP_TS_BIT]);
      if (st_r.ifctrl[`LOSP_SCR_BIT]) begin
        st_nxt.dout[b*DW +: DW] = sc[DW-1:0];
        st_nxt.sout[b]          = sc[DW];
      end else begin
        st_nxt.dout[b*DW +: DW] = d;
        st_nxt.sout[b]          = s;
      end
    end
    st_nxt.oe = !(st_r.pd_sync[1] || st_r.ifctrl[`LOSP_PDMODE_BIT]);
    if (rst_i) begin
      st_nxt        = '0;
      st_nxt.ifctrl = `LOSP_IFCTRL_RST;
      st_nxt.patsel = `LOSP_PATSEL_RST;
      st_nxt.upctrl = `LOSP_UPCTRL_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
  end

  assign wb_dat_o  = st_r.rdat;
  assign wb_ack_o  = st_r.ack;
  assign data_o    = st_r.dout;
  assign strobe_o  = st_r.sout;
  assign data_oe_o = st_r.oe;

  // ==================================================
  // checks
  sequence s_falling;
    st_r.strb_prev && !strobe_i[0];
  endsequence

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
  a_idx_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    s_falling |=> st_r.idx == 3'd1) else $error("pattern index not restarted");
  a_idx_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.idx == 3'd7 && !(st_r.strb_prev && !strobe_i[0])) |=> st_r.idx == 3'd0)
    else $error("pattern index did not wrap");
  a_switch_frame: assert property (@(posedge clk_i) disable iff (rst_i)
    !(st_r.strb_prev && !strobe_i[0]) |=> $stable(st_r.in_sync))
    else $error("pattern switched off a frame boundary");
  a_pd_off: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.ifctrl[`LOSP_PDMODE_BIT] |=> !data_oe_o) else $error("drivers on in power-down");
  a_plain_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st_r.ifctrl[`LOSP_SCR_BIT] && !fg_cal_busy_i && !st_nxt.in_sync &&
     !st_r.patsel[`LOSP_ACT_BIT]) |=> data_o == $past(sample_i))
    else $error("unscrambled sample altered");
  a_w8_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.ifctrl[`LOSP_SCR_BIT] && st_r.ifctrl[9:8] == 2'b11) |=> data_o[3:1] == 3'b000)
    else $error("unused bits not zero in eight-bit mode");
  a_w10_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.ifctrl[`LOSP_SCR_BIT] && st_r.ifctrl[9:8] == 2'b10) |=> data_o[1] == 1'b0)
    else $error("bit one not zero in ten-bit mode");

  // scramble key on the plain sample path of bus A
  sequence s_plain_scr(logic [1:0] wsel);
    st_r.ifctrl[`LOSP_SCR_BIT] && st_r.ifctrl[`LOSP_WID_HI:`LOSP_WID_LO] == wsel &&
    !fg_cal_busy_i && !st_nxt.in_sync && !st_r.patsel[`LOSP_ACT_BIT];
  endsequence

  // frame boundary with software sync source
  sequence s_sw_boundary;
    st_r.strb_prev && !strobe_i[0] && st_r.ifctrl[`LOSP_SYNCSRC_BIT];
  endsequence

  a_w12_low: assert property (@(posedge clk_i) disable iff (rst_i)
    s_plain_scr(2'b00) |=> data_o[1] == $past(sample_i[1]) &&
    data_o[0] == ($past(sample_i[0]) ^ $past(sample_i[1])))
    else $error("twelve-bit low bits wrong");
  a_w11_key: assert property (@(posedge clk_i) disable iff (rst_i)
    s_plain_scr(2'b01) |=> data_o[2] == $past(sample_i[2]) &&
    data_o[1] == ($past(sample_i[2]) ^ $past(sample_i[1])))
    else $error("eleven-bit key bits wrong");
  a_w10_key: assert property (@(posedge clk_i) disable iff (rst_i)
    s_plain_scr(2'b10) |=> data_o[3] == $past(sample_i[3]) &&
    data_o[2] == ($past(sample_i[3]) ^ $past(sample_i[2])))
    else $error("ten-bit key bits wrong");
  a_w8_key: assert property (@(posedge clk_i) disable iff (rst_i)
    s_plain_scr(2'b11) |=> data_o[5] == $past(sample_i[5]) &&
    data_o[4] == ($past(sample_i[5]) ^ $past(sample_i[4])))
    else $error("eight-bit key bits wrong");
  a_midcode_out: assert property (@(posedge clk_i) disable iff (rst_i)
    (fg_cal_busy_i && !st_nxt.in_sync && !st_r.patsel[`LOSP_ACT_BIT] &&
     !st_r.ifctrl[`LOSP_SCR_BIT]) |=> data_o == '0)
    else $error("mid-code missing during calibration");
  a_sync_all: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_nxt.in_sync && st_r.patsel[`LOSP_SYN_HI:`LOSP_SYN_LO] == 2'b10 &&
     !st_r.ifctrl[`LOSP_SCR_BIT]) |=> data_o[DW-1:0] == {DW{$past(strobe_i[0])}})
    else $error("strobe not on all lanes");
  a_pd_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.pd_sync[1] |=> !data_oe_o) else $error("drivers on with power-down pin high");
  a_sw_sync: assert property (@(posedge clk_i) disable iff (rst_i)
    s_sw_boundary |=> st_r.in_sync == $past(st_r.ifctrl[`LOSP_SWSYNC_BIT]))
    else $error("software sync not taken at boundary");
endmodule // losp_top
`default_nettype wire

// *** losp_top_bench.sv ***
// self-checking bench of the output formatter
`timescale 1ns/10ps
`default_nettype none
`include "losp_map.svh"
module losp_top_bench;
  import losp_pkg::*;
  localparam logic [7:0] LANE = `LOSP_LANE_SEQ;
  logic        clk_i, rst_i, pattern_toggle_pin_i, power_down_pin_i, fg_cal_busy_i;
  logic [47:0] sample_i, data_o;
  logic [3:0]  strobe_i, strobe_o, wb_sel_i;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, data_oe_o, rx_v;
  logic [11:0] rx_d;
  logic [1:0]  wid;
  logic [12:0] y;
  int          miscompares, n_checks;
  losp_top losp_top_inst (.clk_i(clk_i), .rst_i(rst_i), .sample_i(sample_i),
    .strobe_i(strobe_i), .pattern_toggle_pin_i(pattern_toggle_pin_i),
    .power_down_pin_i(power_down_pin_i), .fg_cal_busy_i(fg_cal_busy_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .data_o(data_o), .strobe_o(strobe_o), .data_oe_o(data_oe_o));
  losp_rx_model losp_rx_model_inst (.clk_i(clk_i), .y_i(data_o[11:0]), .width_i(wid),
    .oe_i(data_oe_o), .d_o(rx_d), .valid_o(rx_v));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic report_and_stop();
    if (miscompares == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic we,
                    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i  <= we;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, d, 1'b1, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(a, 32'h0, 1'b0, q);
    check(48'(q), 48'(exp));
  endtask
  // expected scrambled word, strobe in bit 12, bit 0 scrambling enabled
  function automatic logic [12:0] scramble_enable(input logic [11:0] d, input logic [1:0] w);
    logic [12:0] r;
    r = {1'b0, d};
    case (w)
      2'd0: begin r[12:2] = r[12:2] ^ {11{d[1] ^ d[0]}}; r[0] = d[1] ^ d[0]; end
      2'd1: begin r[11:3] = r[11:3] ^ {9{d[2] ^ d[1]}}; r[1] = d[2] ^ d[1];
                  r[0] = ^d[2:0]; r[12] = d[1] ^ d[0]; end
      2'd2: begin r[12:4] = r[12:4] ^ {9{d[3] ^ d[2]}}; r[2] = d[3] ^ d[2];
                  r[1] = 1'b0; r[0] = ^{d[3:2], d[0]}; end
      default: begin r[12:6] = r[12:6] ^ {7{d[5] ^ d[4]}}; r[4] = d[5] ^ d[4];
                  r[3:1] = 3'b000; r[0] = ^{d[5:4], d[0]}; end
    endcase
    return r;
  endfunction
  // frames of 5 and 10 words; mode 0 user, 1 lane, 2 strobe on lsb, 3 strobe on all
  task automatic run(input int mode);
    logic s1, s2;
    int idx;
    logic [11:0] e;
    s1 = 1'b0;
    s2 = 1'b0;
    idx = -1;
    for (int t = 0; t < 26; t++) begin
      @(posedge clk_i);
      strobe_i <= {4{t == 0 || t == 5 || t == 15}};
      #1;
      if (s2 && !s1) idx = 0;
      else if (idx >= 0) idx = (idx + 1) % 8;
      for (int b = 0; b < 4; b++) begin
        if (mode == 0) e = {1'b0, 3'(idx), 8'h5A};
        else if (mode == 1) e = {12{LANE[idx[2:0]]}};
        else if (mode == 2) e = {sample_i[b*12+1+:11], s1};
        else e = {12{s1}};
        if (mode < 2 && b % 2 == 0) e[8+b] = ~e[8+b];
        if (idx >= 0) check(48'(data_o[b*12+:12]), 48'(e)); // pattern words
      end
      s2 = s1;
      s1 = (t == 0 || t == 5 || t == 15);
    end
  endtask
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'b1000;
    {pattern_toggle_pin_i, power_down_pin_i, fg_cal_busy_i} = 3'b000;
    {wb_adr_i, wb_dat_i, wb_sel_i, strobe_i, wid} = '0;
    wb_sel_i = 4'hF;
    sample_i = 48'h5C3_A96_3E7_B1D;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 3; a++) rd(8'(4 * a), 32'h0); // reset values
    wr(8'h10, 32'hFFFF);
    rd(8'h10, 32'h0);
    @(posedge clk_i) power_down_pin_i <= 1'b1;
    tick(4);
    check(48'(data_oe_o), 48'h0); // pin power-down
    @(posedge clk_i) power_down_pin_i <= 1'b0;
    tick(4);
    check(48'(data_oe_o), 48'h1); // drivers back
    wr(8'h00, 32'h20);
    tick(2);
    check(48'(data_oe_o), 48'h0); // mode power-down
    for (int w = 0; w < 4; w++) begin
      wid = 2'(w);
      wr(8'h00, 32'h3 | (w << 8));
      tick(2);
      for (int b = 0; b < 4; b++) begin
        y = scramble_enable(sample_i[b*12+:12], 2'(w));
        check(48'({strobe_o[b], data_o[b*12+:12]}), 48'(y)); // scrambled word
      end
      if (w > 1) check(48'({rx_v, rx_d}), 48'({1'b1, sample_i[11:0] & (w == 2 ? 12'hFFD : 12'hFF1)})); // recovered word
    end
    wr(8'h00, 32'h201);
    tick(2);
    for (int b = 0; b < 4; b++) begin
      y = scramble_enable(sample_i[b*12+:12], 2'd2);
      y[0] = sample_i[b*12];
      check(48'({strobe_o[b], data_o[b*12+:12]}), 48'(y)); // bit 0 plain without timestamp
    end
    wr(8'h00, 32'h0);
    tick(2);
    check(data_o, sample_i); // plain samples
    @(posedge clk_i) fg_cal_busy_i <= 1'b1;
    tick(2);
    check(data_o, 48'h0); // mid-code
    @(posedge clk_i) fg_cal_busy_i <= 1'b0;
    for (int i = 0; i < 8; i++) wr(8'(8'h20 + 4 * i), 32'h05A | (i << 8));
    wr(8'h04, 32'h1);
    wr(8'h08, 32'h5);
    run(0);
    wr(8'h08, 32'h15);
    run(1);
    wr(8'h04, 32'h10);
    @(posedge clk_i) pattern_toggle_pin_i <= 1'b1;
    tick(4);
    run(2); // pin selects alignment pattern
    @(posedge clk_i) pattern_toggle_pin_i <= 1'b0;
    wr(8'h04, 32'h20);
    wr(8'h00, 32'h18);
    run(3); // software selects alignment pattern
    report_and_stop();
  end
endmodule // losp_top_bench
`default_nettype wire
